// ===== rtl/pleq_bank.sv
// Bank of programmable logic equations with scan engine and APB register access
//
// Behaviour
// - Each equation combines its inputs through one gate, AND, OR, NAND or NOR, with AND after reset.
// - Each equation has four input slots, each bound to any source or left unassigned.
// - Each slot has its own inversion option, off by default, applied before the gate.
// - A slot's inversion acts, and reads back, only while a source is bound to that slot.
// - The gate result passes a timer with separate on and off delays of 0.00 to 36000.00 s, default zero.
// - The timer gives a plain delayed result and a latched copy held until reset.
// - The latch set input, driven by the timer result, has an inversion option that is off by default.
// - A selectable, optionally inverted reset source clears the latch, as does a count that leaves the equation out; with none bound only the count clears it.
// - All enabled equations are evaluated in ascending index order, scan after scan without pause.
// - A consumer of a lower-indexed equation sees its change within the same scan.
// - A consumer of a higher-indexed equation sees its change one scan later.
// - The equation count is one of 0, 5, 10, 20, 40 or 80, and 20 after reset.
// - Equation outputs are selectable sources beside the external inputs.
// - Each equation exposes gate result, timer result, latched result and its complement.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
module pleq_bank #(
    parameter int TICK_CYCLES = pleq_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Source signals from protection, breaker, alarms and module inputs
    input wire logic [pleq_pkg::EXT_NUM-1:0] ext_in,
    // Equation results
    output pleq_pkg::pleq_out_s eq_out [pleq_pkg::EQ_MAX]
);

    typedef enum {SCAN_START, SCAN_EVAL} pleq_scan_e;

    pleq_pkg::pleq_cfg_s cfg_r [pleq_pkg::EQ_MAX];
    pleq_pkg::pleq_out_s out_r [pleq_pkg::EQ_MAX];
    logic [pleq_pkg::DLY_W-1:0] cnt_r [pleq_pkg::EQ_MAX];
    logic [6:0] count_r;
    logic [6:0] idx_r;
    pleq_scan_e scan_r;
    logic [15:0] scans_r;
    logic [pleq_pkg::EXT_NUM-1:0] ext_meta_r;
    logic [pleq_pkg::EXT_NUM-1:0] ext_sync_r;
    logic [31:0] tick_cnt_r;
    logic tick_pend_r;
    logic scan_tick_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    logic [4*pleq_pkg::EQ_MAX-1:0] eq_bits;
    logic [pleq_pkg::SRC_LAST:0] src_vec;
    pleq_pkg::pleq_cfg_s cur;
    pleq_pkg::pleq_out_s res_nxt;
    logic [pleq_pkg::DLY_W-1:0] cnt_nxt;
    logic and_mode;
    logic [3:0] slot;
    logic gate_res;
    logic [pleq_pkg::DLY_W-1:0] dly;
    logic latch_set;
    logic latch_rst;
    logic tick_wrap;
    logic scan_begin;
    logic wr_en;
    pleq_pkg::pleq_dec_s dec_a;

    function automatic logic src_bound(input logic [pleq_pkg::SRC_W-1:0] sel);
        return (sel != pleq_pkg::SRC_NONE) && (sel <= pleq_pkg::SRC_LAST);
    endfunction

    function automatic logic src_level(input logic [pleq_pkg::SRC_W-1:0] sel,
                                       input logic [pleq_pkg::SRC_LAST:0] vec);
        return src_bound(sel) ? vec[sel] : 1'b0;
    endfunction

    function automatic pleq_pkg::pleq_dec_s decode(input logic [15:0] a);
        pleq_pkg::pleq_dec_s d;
        logic [15:0] off;
        d = '0;
        off = a - pleq_pkg::ADDR_EQ_BASE;
        if (a == pleq_pkg::ADDR_COUNT || a == pleq_pkg::ADDR_STATUS) begin
            d.hit = 1'b1;
            d.global = 1'b1;
        end else if (a >= pleq_pkg::ADDR_EQ_BASE && a < pleq_pkg::ADDR_EQ_END) begin
            d.eq = off[11:5];
            d.word = off[4:2];
            d.hit = (off[1:0] == 2'h0) && (off[4:2] <= pleq_pkg::WORD_STATE);
        end
        return d;
    endfunction

    function automatic logic count_legal(input logic [31:0] v);
        return v == 32'(pleq_pkg::CNT_0) || v == 32'(pleq_pkg::CNT_5) || v == 32'(pleq_pkg::CNT_10)
            || v == 32'(pleq_pkg::CNT_20) || v == 32'(pleq_pkg::CNT_40) || v == 32'(pleq_pkg::CNT_80);
    endfunction

    function automatic logic [pleq_pkg::DLY_W-1:0] clamp_dly(input logic [31:0] v);
        return (v > 32'(pleq_pkg::DLY_MAX)) ? pleq_pkg::DLY_MAX : v[pleq_pkg::DLY_W-1:0];
    endfunction

    // Source pins come from other logic and other timing, so they are synchronised first
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_meta_r <= '0;
            ext_sync_r <= '0;
        end else begin
            ext_meta_r <= ext_in;
            ext_sync_r <= ext_meta_r;
        end
    end

    // 10 ms tick prescaler
    assign tick_wrap = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= '0;
        end else if (tick_wrap) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end

    // A tick arriving in the capture cycle is kept for the next scan
    assign scan_begin = (scan_r == SCAN_START) && (count_r != pleq_pkg::CNT_0);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tick_pend_r <= 1'b0;
            scan_tick_r <= 1'b0;
        end else begin
            tick_pend_r <= tick_wrap | (tick_pend_r & ~scan_begin);
            if (scan_begin) begin
                scan_tick_r <= tick_pend_r;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scan_r <= SCAN_START;
            idx_r <= '0;
            scans_r <= '0;
        end else begin
            case (scan_r)
                SCAN_START: begin
                    idx_r <= '0;
                    if (scan_begin) begin
                        scan_r <= SCAN_EVAL;
                    end
                end
                SCAN_EVAL: begin
                    if (idx_r + 7'h01 >= count_r) begin
                        scan_r <= SCAN_START;
                        scans_r <= scans_r + 16'h0001;
                    end else begin
                        idx_r <= idx_r + 7'h01;
                    end
                end
                default: begin
                    scan_r <= SCAN_START;
                end
            endcase
        end
    end

    // equation outputs join the source space
    always_comb begin
        for (int i = 0; i < pleq_pkg::EQ_MAX; i++) begin
            eq_bits[4*i +: 4] = {out_r[i].latched_n, out_r[i].latched, out_r[i].timer_out, out_r[i].gate_out};
        end
    end
    assign src_vec = {eq_bits, ext_sync_r, 1'b0};

    // Evaluation of the equation under the scan pointer
    always_comb begin
        cur = cfg_r[idx_r];
        and_mode = (cur.gate == pleq_pkg::GATE_AND) || (cur.gate == pleq_pkg::GATE_NAND);
        for (int k = 0; k < 4; k++) begin
            slot[k] = src_bound(cur.src[k]) ? (src_level(cur.src[k], src_vec) ^ cur.inv[k]) : and_mode;
        end
        gate_res = and_mode ? &slot : |slot;
        if (cur.gate == pleq_pkg::GATE_NAND || cur.gate == pleq_pkg::GATE_NOR) begin
            gate_res = ~gate_res;
        end
        res_nxt = out_r[idx_r];
        res_nxt.gate_out = gate_res;
        dly = gate_res ? cur.on_dly : cur.off_dly;
        cnt_nxt = '0;
        if (gate_res != out_r[idx_r].timer_out) begin
            if (cnt_r[idx_r] >= dly) begin
                res_nxt.timer_out = gate_res;
            end else begin
                cnt_nxt = cnt_r[idx_r] + pleq_pkg::DLY_W'(scan_tick_r);
            end
        end
        latch_set = res_nxt.timer_out ^ cur.set_inv;
        latch_rst = src_bound(cur.rst_src) & (src_level(cur.rst_src, src_vec) ^ cur.rst_inv);
        if (latch_rst) begin
            res_nxt.latched = 1'b0;
        end else if (latch_set) begin
            res_nxt.latched = 1'b1;
        end
        res_nxt.latched_n = ~res_nxt.latched;
    end

    // results land in place, so later slots see them this scan and earlier ones next scan
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < pleq_pkg::EQ_MAX; i++) begin
                out_r[i] <= 4'h1;
                cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < pleq_pkg::EQ_MAX; i++) begin
                // Equations beyond the planned count rest in their reset state
                if (7'(i) >= count_r) begin
                    out_r[i] <= 4'h1;
                    cnt_r[i] <= '0;
                end
            end
            if (scan_r == SCAN_EVAL && idx_r < count_r) begin
                out_r[idx_r] <= res_nxt;
                cnt_r[idx_r] <= cnt_nxt;
            end
        end
    end

    // APB: one wait-free access phase, setup cycle prepares the answer
    assign dec_a = decode(paddr);
    assign wr_en = psel & penable & pready_r & pwrite & dec_a.hit;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_r <= pleq_pkg::EQ_DEFAULT;
        end else if (wr_en && dec_a.global && paddr == pleq_pkg::ADDR_COUNT && count_legal(pwdata)) begin
            count_r <= pwdata[6:0];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < pleq_pkg::EQ_MAX; i++) begin
                cfg_r[i] <= '0;
            end
        end else if (wr_en && !dec_a.global) begin
            case (dec_a.word)
                pleq_pkg::WORD_CTRL: begin
                    cfg_r[dec_a.eq].gate <= pleq_pkg::pleq_gate_e'(pwdata[pleq_pkg::CTRL_GATE_LSB +: 2]);
                    cfg_r[dec_a.eq].inv <= pwdata[pleq_pkg::CTRL_INV_LSB +: 4];
                    cfg_r[dec_a.eq].set_inv <= pwdata[pleq_pkg::CTRL_SET_INV_BIT];
                    cfg_r[dec_a.eq].rst_inv <= pwdata[pleq_pkg::CTRL_RST_INV_BIT];
                end
                pleq_pkg::WORD_SRC01: begin
                    cfg_r[dec_a.eq].src[0] <= pwdata[pleq_pkg::SRC_W-1:0];
                    cfg_r[dec_a.eq].src[1] <= pwdata[pleq_pkg::SRC_HI_LSB +: pleq_pkg::SRC_W];
                end
                pleq_pkg::WORD_SRC23: begin
                    cfg_r[dec_a.eq].src[2] <= pwdata[pleq_pkg::SRC_W-1:0];
                    cfg_r[dec_a.eq].src[3] <= pwdata[pleq_pkg::SRC_HI_LSB +: pleq_pkg::SRC_W];
                end
                pleq_pkg::WORD_RST_SRC: begin
                    cfg_r[dec_a.eq].rst_src <= pwdata[pleq_pkg::SRC_W-1:0];
                end
                // Delays beyond 36000.00 s saturate rather than wrap
                pleq_pkg::WORD_ON_DLY: begin
                    cfg_r[dec_a.eq].on_dly <= clamp_dly(pwdata);
                end
                pleq_pkg::WORD_OFF_DLY: begin
                    cfg_r[dec_a.eq].off_dly <= clamp_dly(pwdata);
                end
                default: begin
                end
            endcase
        end
    end

    // Read data and error are registered in the setup cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (psel && !penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= ~dec_a.hit;
            prdata_r <= '0;
            if (dec_a.global) begin
                prdata_r <= (paddr == pleq_pkg::ADDR_COUNT) ? 32'(count_r) : 32'(scans_r);
            end else if (dec_a.hit) begin
                case (dec_a.word)
                    pleq_pkg::WORD_CTRL: begin
                        prdata_r[pleq_pkg::CTRL_GATE_LSB +: 2] <= cfg_r[dec_a.eq].gate;
                        // inversion reads back only where a source is bound
                        for (int k = 0; k < 4; k++) begin
                            prdata_r[pleq_pkg::CTRL_INV_LSB + k] <=
                                cfg_r[dec_a.eq].inv[k] & src_bound(cfg_r[dec_a.eq].src[k]);
                        end
                        prdata_r[pleq_pkg::CTRL_SET_INV_BIT] <= cfg_r[dec_a.eq].set_inv;
                        prdata_r[pleq_pkg::CTRL_RST_INV_BIT] <= cfg_r[dec_a.eq].rst_inv;
                    end
                    pleq_pkg::WORD_SRC01: begin
                        prdata_r[pleq_pkg::SRC_W-1:0] <= cfg_r[dec_a.eq].src[0];
                        prdata_r[pleq_pkg::SRC_HI_LSB +: pleq_pkg::SRC_W] <= cfg_r[dec_a.eq].src[1];
                    end
                    pleq_pkg::WORD_SRC23: begin
                        prdata_r[pleq_pkg::SRC_W-1:0] <= cfg_r[dec_a.eq].src[2];
                        prdata_r[pleq_pkg::SRC_HI_LSB +: pleq_pkg::SRC_W] <= cfg_r[dec_a.eq].src[3];
                    end
                    pleq_pkg::WORD_RST_SRC: begin
                        prdata_r[pleq_pkg::SRC_W-1:0] <= cfg_r[dec_a.eq].rst_src;
                    end
                    pleq_pkg::WORD_ON_DLY: begin
                        prdata_r[pleq_pkg::DLY_W-1:0] <= cfg_r[dec_a.eq].on_dly;
                    end
                    pleq_pkg::WORD_OFF_DLY: begin
                        prdata_r[pleq_pkg::DLY_W-1:0] <= cfg_r[dec_a.eq].off_dly;
                    end
                    pleq_pkg::WORD_STATE: begin
                        prdata_r[3:0] <= out_r[dec_a.eq];
                        prdata_r[pleq_pkg::STATE_CNT_LSB +: pleq_pkg::DLY_W] <= cnt_r[dec_a.eq];
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign eq_out = out_r;

endmodule // pleq_bank

// ===== rtl/pleq_pkg.sv
// Constants, types and register map of the programmable logic equation bank
package pleq_pkg;

    // Bank size and source space
    localparam int EQ_MAX = 80;
    localparam logic [6:0] EQ_DEFAULT = 7'h14;
    localparam int EXT_NUM = 64;
    localparam int SRC_W = 9;
    localparam logic [SRC_W-1:0] SRC_NONE = 9'h000;
    localparam logic [SRC_W-1:0] SRC_LAST = 9'h180;

    // Legal equation counts
    localparam logic [6:0] CNT_0 = 7'h00;
    localparam logic [6:0] CNT_5 = 7'h05;
    localparam logic [6:0] CNT_10 = 7'h0a;
    localparam logic [6:0] CNT_20 = 7'h14;
    localparam logic [6:0] CNT_40 = 7'h28;
    localparam logic [6:0] CNT_80 = 7'h50;

    // Timing: delays count in 10 ms ticks, 0.00 to 36000.00 s
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 10_000_000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DLY_W = 22;
    localparam logic [DLY_W-1:0] DLY_MAX = 22'h36_ee80;

    // Register map (byte addresses)
    localparam logic [15:0] ADDR_COUNT = 16'h0000;
    localparam logic [15:0] ADDR_STATUS = 16'h0004;
    localparam logic [15:0] ADDR_EQ_BASE = 16'h1000;
    localparam logic [15:0] ADDR_EQ_END = 16'h1a00;
    localparam logic [2:0] WORD_CTRL = 3'h0;
    localparam logic [2:0] WORD_SRC01 = 3'h1;
    localparam logic [2:0] WORD_SRC23 = 3'h2;
    localparam logic [2:0] WORD_RST_SRC = 3'h3;
    localparam logic [2:0] WORD_ON_DLY = 3'h4;
    localparam logic [2:0] WORD_OFF_DLY = 3'h5;
    localparam logic [2:0] WORD_STATE = 3'h6;

    // Field positions
    localparam int CTRL_GATE_LSB = 0;
    localparam int CTRL_INV_LSB = 4;
    localparam int CTRL_SET_INV_BIT = 8;
    localparam int CTRL_RST_INV_BIT = 9;
    localparam int SRC_HI_LSB = 16;
    localparam int STATE_CNT_LSB = 8;

    typedef enum logic [1:0] {GATE_AND, GATE_OR, GATE_NAND, GATE_NOR} pleq_gate_e;

    typedef struct packed {
        pleq_gate_e gate;
        logic [3:0] inv;
        logic set_inv;
        logic rst_inv;
        logic [3:0][SRC_W-1:0] src;
        logic [SRC_W-1:0] rst_src;
        logic [DLY_W-1:0] on_dly;
        logic [DLY_W-1:0] off_dly;
    } pleq_cfg_s;

    typedef struct packed {
        logic gate_out;
        logic timer_out;
        logic latched;
        logic latched_n;
    } pleq_out_s;

    typedef struct packed {
        logic hit;
        logic global;
        logic [6:0] eq;
        logic [2:0] word;
    } pleq_dec_s;

endpackage

// ===== sim/pleq_bank_assertions.sv
// Port checker for the logic equation bank
`timescale 1ns/10ps
module pleq_bank_assertions #(
    parameter int TICK_CYCLES = 20
) (
    // Clock and reset
    input logic clock,
    input logic resetn,
    // APB
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [15:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // Sources and results
    input logic [pleq_pkg::EXT_NUM-1:0] ext_in,
    input pleq_pkg::pleq_out_s eq_out [pleq_pkg::EQ_MAX]
);
    logic [6:0] cnt_r;
    logic [7:0] quiet_r;
    logic comp_ok;
    logic idle_ok;
    logic unmapped;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    assign unmapped = (paddr >= 16'h0008 && paddr < pleq_pkg::ADDR_EQ_BASE) || paddr >= pleq_pkg::ADDR_EQ_END
        || (paddr >= pleq_pkg::ADDR_EQ_BASE && paddr[4:2] == 3'h7) || paddr[1:0] != 2'h0;
    always_comb begin
        comp_ok = 1'b1;
        idle_ok = 1'b1;
        for (int i = 0; i < pleq_pkg::EQ_MAX; i++) begin
            if (eq_out[i].latched_n == eq_out[i].latched) comp_ok = 1'b0;
            if (i >= int'(cnt_r) && eq_out[i] != 4'h1) idle_ok = 1'b0;
        end
    end
    // Shadow of the equation count, and time since it was last written
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= pleq_pkg::EQ_DEFAULT;
            quiet_r <= 8'h00;
        end else if (psel && penable && pready && pwrite && paddr == pleq_pkg::ADDR_COUNT && pwdata[31:7] == 25'h0
                     && pwdata[6:0] inside {7'h00, 7'h05, 7'h0a, 7'h14, 7'h28, 7'h50}) begin
            cnt_r <= pwdata[6:0];
            quiet_r <= 8'h00;
        end else if (quiet_r != 8'hff) begin
            quiet_r <= quiet_r + 8'h01;
        end
    end
    AST_ACCESS_ANSWER:
        assert property (psel && !penable |=> pready) else $error("no answer in access phase");
    AST_PREADY_PULSE:
        assert property (pready |=> !pready) else $error("pready longer than one cycle");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready && psel && penable) else $error("pslverr outside access");
    AST_ERR_UNMAPPED:
        assert property (psel && !penable |=> pslverr == $past(unmapped)) else $error("pslverr wrong for address");
    AST_COUNT_READ:
        assert property (psel && !penable && !pwrite && paddr == pleq_pkg::ADDR_COUNT |=> prdata == {25'h0, cnt_r})
        else $error("count readback wrong");
    AST_COMPLEMENT:
        assert property (comp_ok) else $error("latched_n not the complement of latched");
    AST_RESET_GATE:
        assert property ($rose(resetn) |-> ##[1:30] eq_out[0].gate_out) else $error("default gate not AND");
    AST_INACTIVE_IDLE:
        assert property (quiet_r == 8'hff |-> idle_ok) else $error("equation beyond count not idle");
endmodule // pleq_bank_assertions

// ===== sim/pleq_partner.sv
// Far side: source contacts feeding the bank and relays following it
`timescale 1ns/10ps
module pleq_partner (
    // Clock
    input wire logic clock,
    // Requested source levels and pacing
    input wire logic [pleq_pkg::EXT_NUM-1:0] level_req,
    input wire logic slow,
    // Bank side
    output logic [pleq_pkg::EXT_NUM-1:0] ext_in,
    input pleq_pkg::pleq_out_s eq_out [pleq_pkg::EQ_MAX],
    // Relay image of latched results
    output logic [pleq_pkg::EQ_MAX-1:0] relay_q
);
    logic [pleq_pkg::EXT_NUM-1:0] stage_r = '0;
    logic [pleq_pkg::EXT_NUM-1:0] now_r = '0;
    // A slow contact settles one cycle later
    assign ext_in = slow ? stage_r : now_r;
    always @(posedge clock) begin
        now_r <= level_req;
        stage_r <= now_r;
        for (int i = 0; i < pleq_pkg::EQ_MAX; i++) relay_q[i] <= eq_out[i].latched;
    end
endmodule // pleq_partner

// ===== sim/test_pleq_bank.sv
// Self-checking bench for the logic equation bank
`timescale 1ns/10ps
module test_pleq_bank;
    localparam int TICKS = 20;
    localparam int SCAN = 21;
    logic clock;
    logic resetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [pleq_pkg::EXT_NUM-1:0] ext_in;
    logic [pleq_pkg::EXT_NUM-1:0] level_req;
    logic slow;
    logic [pleq_pkg::EQ_MAX-1:0] relay_q;
    pleq_pkg::pleq_out_s eq_out [pleq_pkg::EQ_MAX];
    int error_cnt;
    int check_count;
    logic [31:0] rd;
    logic err;
    pleq_bank #(.TICK_CYCLES(TICKS)) i_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_in(ext_in), .eq_out(eq_out));
    pleq_partner i_far (.clock(clock), .level_req(level_req), .slow(slow), .ext_in(ext_in), .eq_out(eq_out),
        .relay_q(relay_q));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [15:0] ea(input int e, input int w);
        return pleq_pkg::ADDR_EQ_BASE + 16'(e * 32 + w * 4);
    endfunction
    initial begin
        logic [1:0] g;
        logic inv;
        logic x;
        logic ex;
        int t0, t1, t2, t3, n;
        logic [31:0] s1;
        logic [6:0] legal [6];
        legal = '{pleq_pkg::CNT_0, pleq_pkg::CNT_5, pleq_pkg::CNT_10, pleq_pkg::CNT_20, pleq_pkg::CNT_40,
            pleq_pkg::CNT_80};
        error_cnt = 0;
        check_count = 0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        level_req = '0;
        resetn = 1'b0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        apb(1'b0, pleq_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'h0000_0014);
        apb(1'b0, ea(0, 0), 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, ea(0, 4), 32'h0);
        chk(rd, 32'h0000_0000);
        chk(eq_out[0].gate_out, 32'h1);
        chk(eq_out[0].latched_n, 32'h0);
        apb(1'b0, 16'h0008, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, ea(0, 7), 32'h1);
        chk(err, 32'h1);
        $display("test reset done");
        // Slots 0 and 1 bound, slot 2 inversion set while unbound
        apb(1'b1, ea(0, 1), 32'h0002_0001);
        for (int i = 0; i < 32; i++) begin
            g = i[1:0];
            inv = i[4];
            apb(1'b1, ea(0, 0), {24'h0, 3'h2, inv, 2'h0, g});
            level_req <= {62'h0, i[3], i[2]};
            repeat (2 * SCAN + 4) @(posedge clock);
            x = i[2] ^ inv;
            ex = g[0] ? (x | i[3]) : (x & i[3]);
            chk(eq_out[0].gate_out, ex ^ g[1]);
            apb(1'b0, ea(0, 0), 32'h0);
            chk(rd, {24'h0, 3'h0, inv, 2'h0, g});
        end
        $display("test gates done");
        // Lower source eq0 to eq1, higher source eq3 to eq2
        apb(1'b1, ea(0, 0), 32'h0);
        apb(1'b1, ea(0, 1), 32'h3);
        apb(1'b1, ea(1, 1), 32'd65);
        apb(1'b1, ea(3, 1), 32'h3);
        apb(1'b1, ea(2, 1), 32'd77);
        level_req <= '0;
        repeat (3 * SCAN) @(posedge clock);
        level_req <= 64'h4;
        {t0, t1, t2, t3} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1};
        for (int i = 0; i < 150; i++) begin
            @(posedge clock);
            #1;
            if (eq_out[0].gate_out && t0 < 0) t0 = i;
            if (eq_out[1].gate_out && t1 < 0) t1 = i;
            if (eq_out[2].gate_out && t2 < 0) t2 = i;
            if (eq_out[3].gate_out && t3 < 0) t3 = i;
        end
        chk(t1 - t0, 32'd1);
        chk(t2 - t3, SCAN - 1);
        $display("test cascade done");
        // Eq4: on delay of three ticks, latch behind it
        slow <= 1'b1;
        apb(1'b1, ea(4, 3), 32'h5);
        apb(1'b1, ea(4, 0), 32'h200);
        apb(1'b1, ea(4, 1), 32'h4);
        apb(1'b1, ea(4, 4), 32'h3);
        repeat (2 * SCAN) @(posedge clock);
        chk({eq_out[4].timer_out, eq_out[4].latched}, 32'h0);
        apb(1'b1, ea(4, 0), 32'h0);
        apb(1'b1, ea(4, 3), 32'h0);
        level_req <= 64'h8;
        repeat (2 * SCAN + 4) @(posedge clock);
        chk({eq_out[4].gate_out, eq_out[4].timer_out}, 32'h2);
        n = 0;
        while (eq_out[4].timer_out !== 1'b1 && n < 200) begin
            @(posedge clock);
            n++;
        end
        chk(n + 2 * SCAN + 4 >= 3 * TICKS && n < 200, 32'h1);
        @(posedge clock);
        chk({eq_out[4].latched, relay_q[4]}, 32'h3);
        apb(1'b1, ea(4, 5), 32'h2);
        level_req <= 64'h0;
        repeat (SCAN + 8) @(posedge clock);
        chk({eq_out[4].gate_out, eq_out[4].timer_out}, 32'h1);
        repeat (2 * SCAN + 6) @(posedge clock);
        chk({eq_out[4].timer_out, eq_out[4].latched}, 32'h1);
        apb(1'b1, ea(4, 5), 32'h0);
        apb(1'b1, ea(4, 3), 32'h5);
        level_req <= 64'h18;
        repeat (200) @(posedge clock);
        chk({eq_out[4].timer_out, eq_out[4].latched}, 32'h2);
        level_req <= 64'h8;
        repeat (2 * SCAN + 6) @(posedge clock);
        chk(eq_out[4].latched, 32'h1);
        apb(1'b1, ea(4, 0), 32'h200);
        repeat (2 * SCAN) @(posedge clock);
        chk(eq_out[4].latched, 32'h0);
        apb(1'b1, ea(4, 0), 32'h100);
        level_req <= 64'h0;
        repeat (2 * SCAN + 6) @(posedge clock);
        chk({eq_out[4].timer_out, eq_out[4].latched}, 32'h1);
        slow <= 1'b0;
        $display("test timer and latch done");
        // Every legal count, then a refused one, then a short bank
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, pleq_pkg::ADDR_COUNT, {25'h0, legal[i]});
            apb(1'b0, pleq_pkg::ADDR_COUNT, 32'h0);
            chk(rd, {25'h0, legal[i]});
        end
        apb(1'b1, pleq_pkg::ADDR_COUNT, 32'h7);
        apb(1'b0, pleq_pkg::ADDR_COUNT, 32'h0);
        chk(rd, 32'h0000_0050);
        apb(1'b1, pleq_pkg::ADDR_COUNT, 32'h5);
        repeat (300) @(posedge clock);
        chk(eq_out[10], 32'h1);
        apb(1'b0, pleq_pkg::ADDR_STATUS, 32'h0);
        s1 = rd;
        repeat (60) @(posedge clock);
        apb(1'b0, pleq_pkg::ADDR_STATUS, 32'h0);
        chk((rd - s1) inside {32'd10, 32'd11}, 32'h1);
        $display("test count done");
        wrap_up();
    end
endmodule // test_pleq_bank
bind pleq_bank pleq_bank_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_in(ext_in), .eq_out(eq_out));
